/* src/chp_defs.svh */
`ifndef CHP_DEFS_SVH
`define CHP_DEFS_SVH

// ==========================================================================
// Register map (index of each control register)
`define CHP_REG_FIRST 3'h1
`define CHP_REG_LAST 3'h6
`define CHP_REG_MODE 3'h2
`define CHP_REG_PROTO 3'h4

// ==========================================================================
// Field positions
`define CHP_PROTO_SEL_BIT 7
`define CHP_GPIO_OUT_BIT 1
`define CHP_GPIO_IN_BIT 0
`define CHP_SS_SEL_VAL 2'h1

// ==========================================================================
// Reset values
`define CHP_RST_REG1 8'h00
`define CHP_RST_REG2 8'h00
`define CHP_RST_REG3 8'h00
`define CHP_RST_REG4 8'h80
`define CHP_RST_REG5 8'h00
`define CHP_RST_REG6 8'h00

// ==========================================================================
// Start/stop link word layout and command words
`define CHP_SS_BITS 5'h0f
`define CHP_SS_BCAST_ON 15'h78ff
`define CHP_SS_BCAST_OFF 15'h7800

// ==========================================================================
// Two-wire serial bus constants
`define CHP_I2C_MODE_BCAST 5'h1f
`define CHP_I2C_MODE_DEFAULT 5'h00
`define CHP_I2C_ADDR_HI 3'h4
`define CHP_MAX_CODECS 5'h10

`endif

/* src/chp_pkg.sv */
package chp_pkg;

  // ========================================================================
  // Control register file as seen by the codec core
  typedef logic [6:1][7:0] chpCtrlRegs_t;

  // ========================================================================
  // Cascade position delivered by automatic cascade detection
  typedef struct packed {
    logic valid;
    logic [3:0] addr;
    logic [4:0] total;
  } chpCascade_t;

  // ========================================================================
  // Host pin group: open-drain data, input clock
  typedef struct packed {
    logic sdaOut;
    logic sdaOe;
  } chpPinOut_t;

  // ========================================================================
  // Local write port from the codec core
  typedef struct packed {
    logic en;
    logic [2:0] idx;
    logic [7:0] data;
  } chpLocalWr_t;

  typedef enum logic [2:0] {
    CHP_I2C_IDLE,
    CHP_I2C_RX,
    CHP_I2C_ACK,
    CHP_I2C_TX,
    CHP_I2C_MACK
  } chpI2cState_t;

  typedef enum logic [1:0] {
    CHP_MODE_GPIO,
    CHP_MODE_SS,
    CHP_MODE_I2C
  } chpMode_t;

endpackage

/* src/chp_pin_sync.sv */
`timescale 1ns/1ps
// Three-stage pin synchroniser; output moves only when stages two and three agree
module chp_pin_sync #(
  parameter int WIDTH = 2,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Pins
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinSync
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] held;
  } chpSyncState_t;

  chpSyncState_t st_q;
  chpSyncState_t st_d;

  if (WIDTH < 1)
  begin : g_width_check
    $error("chp_pin_sync: WIDTH must be at least 1");
  end

  always_comb
  begin
    st_d = st_q;
    st_d.s1 = pinIn;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (st_q.s2[i] == st_q.s3[i])
        st_d.held[i] = st_q.s3[i];
    end
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
      st_q <= {4{INIT}};
    else
      st_q <= st_d;
  end

  assign pinSync = st_q.held;

endmodule // chp_pin_sync

/* src/chp_cascade_xfer.sv */
`timescale 1ns/1ps
`include "chp_defs.svh"
// Carries the cascade detection result from the link clock into the master clock
module chp_cascade_xfer (
  // Link side
  input wire logic linkClock,
  input wire logic linkNrst,
  input wire logic detectDone,
  input wire logic [3:0] detectPos,
  input wire logic [4:0] detectTotal,
  // Master clock side
  input wire logic clock,
  input wire logic nrst,
  output chp_pkg::chpCascade_t cascade
);
  import chp_pkg::*;

  // ========================================================================
  // Link domain: hold the word, flip a toggle
  typedef struct packed {
    logic tog;
    logic [3:0] pos;
    logic [4:0] total;
  } chpLink_t;

  chpLink_t lk_q;
  chpLink_t lk_d;

  always_comb
  begin
    lk_d = lk_q;
    // Totals outside 1..16 or a position past the end are not a valid chain
    if (detectDone && detectTotal != 5'h00 && detectTotal <= `CHP_MAX_CODECS
        && {1'b0, detectPos} < detectTotal)
    begin
      lk_d.pos = detectPos;
      lk_d.total = detectTotal;
      lk_d.tog = ~lk_q.tog;
    end
  end

  always_ff @(posedge linkClock)
  begin
    if (!linkNrst)
      lk_q <= '0;
    else
      lk_q <= lk_d;
  end

  // ========================================================================
  // Master domain: toggle through three flops, word sampled once stable
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic seen;
    chpCascade_t casc;
  } chpSys_t;

  chpSys_t sy_q;
  chpSys_t sy_d;

  always_comb
  begin
    sy_d = sy_q;
    sy_d.s1 = lk_q.tog;
    sy_d.s2 = sy_q.s1;
    sy_d.s3 = sy_q.s2;
    // Held word has been stable for at least two master edges here
    if (sy_q.s2 == sy_q.s3 && sy_q.s3 != sy_q.seen)
    begin
      sy_d.seen = sy_q.s3;
      sy_d.casc.valid = 1'b1;
      sy_d.casc.addr = lk_q.pos;
      sy_d.casc.total = lk_q.total;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
      sy_q <= '0;
    else
      sy_q <= sy_d;
  end

  assign cascade = sy_q.casc;

endmodule // chp_cascade_xfer

/* src/chp_host_port.sv */
`timescale 1ns/1ps
`include "chp_defs.svh"
// Summary of operation
// - Register 4 top bit: 1 selects two-wire read/write bus, 0 makes pins GPIO unless register 2 selects the start/stop link.
// - In GPIO use data pin outputs bit D1, clock pin is sampled into D0.
// - Cascade detection counts up to 16 codecs; each gets its position as address.
// - Start/stop write link is used when register 2 bits D1-D0 equal 01.
// - Start/stop words: idle high, low start bit, word MSB first, high stop bit.
// - Start/stop word 111 1000 1111 1111 enters broadcast mode.
// - In broadcast, address bits D14-D11 are ignored; every codec writes the register.
// - Start/stop word 111 1000 0000 0000 leaves broadcast mode.
// - Bus write: address byte with write bit 0, mode/index byte, then data bytes.
// - Bus read: set index by two-byte write, restart, address with read bit 1, data.
// - Index increments after every register byte read or written over the bus.
// - Write burst keeps storing bytes until stop or repeated start.
// - Address byte and broadcast writes are acknowledged only by cascade address 0000.
// - Six control registers reachable; start/stop link writes only.
module chp_host_port (
  // Clocks and resets
  input wire logic clock,
  input wire logic nrst,
  input wire logic linkClock,
  input wire logic linkNrst,
  // Host pins
  input wire logic sclIn,
  input wire logic sdaIn,
  output chp_pkg::chpPinOut_t sdaPin,
  // Cascade detection, link clock domain
  input wire logic detectDone,
  input wire logic [3:0] detectPos,
  input wire logic [4:0] detectTotal,
  // Codec core side
  input wire chp_pkg::chpLocalWr_t localWr,
  output chp_pkg::chpCtrlRegs_t ctrlRegs,
  output chp_pkg::chpMode_t hostMode,
  output logic broadcastActive,
  output logic [3:0] cascadeAddr,
  output logic isMaster
);
  import chp_pkg::*;

  // ========================================================================
  // Helpers
  function automatic logic idxValid(input logic [2:0] idx);
    return idx >= `CHP_REG_FIRST && idx <= `CHP_REG_LAST;
  endfunction

  function automatic logic [7:0] regRead(input chpCtrlRegs_t regs, input logic [2:0] idx);
    return idxValid(idx) ? regs[idx] : 8'h00;
  endfunction

  function automatic chpMode_t modeOf(input chpCtrlRegs_t regs);
    if (regs[`CHP_REG_PROTO][`CHP_PROTO_SEL_BIT])
      return CHP_MODE_I2C;
    else if (regs[`CHP_REG_MODE][1:0] == `CHP_SS_SEL_VAL)
      return CHP_MODE_SS;
    else
      return CHP_MODE_GPIO;
  endfunction

  // ========================================================================
  // Pin synchronisers and cascade crossing
  logic [1:0] pinSync;
  chpCascade_t casc;

  chp_pin_sync #(
    .WIDTH(2),
    .INIT(2'h3)
  ) u_sync (
    .clock(clock),
    .nrst(nrst),
    .pinIn({sclIn, sdaIn}),
    .pinSync(pinSync)
  );

  chp_cascade_xfer u_casc (
    .linkClock(linkClock),
    .linkNrst(linkNrst),
    .detectDone(detectDone),
    .detectPos(detectPos),
    .detectTotal(detectTotal),
    .clock(clock),
    .nrst(nrst),
    .cascade(casc)
  );

  logic sclS;
  logic sdaS;
  assign sclS = pinSync[1];
  assign sdaS = pinSync[0];

  // ========================================================================
  // State
  typedef struct packed {
    chpCtrlRegs_t regs;
    chpMode_t mode;
    logic sclPrev;
    logic sdaPrev;
    logic sdaOut;
    logic sdaOe;
    // Two-wire bus
    chpI2cState_t i2c;
    logic [2:0] bitCnt;
    logic [7:0] shift;
    logic [1:0] byteNo;
    logic hit;
    logic rd;
    logic pendAck;
    logic mAck;
    logic [2:0] index;
    logic bcastI2c;
    // Start/stop link
    logic ssAct;
    logic [4:0] ssCnt;
    logic [14:0] ssWord;
    logic bcastSs;
    // Core view
    logic bcastOut;
    logic [3:0] addr;
    logic master;
  } chpHostState_t;

  chpHostState_t st_q;
  chpHostState_t st_d;

  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  logic [7:0] rxByte;
  logic addrMatch;
  logic wrEn;
  logic [2:0] wrIdx;
  logic [7:0] wrData;
  logic ackOwner;
  logic [7:0] rdByte;

  always_comb
  begin
    st_d = st_q;
    st_d.sclPrev = sclS;
    st_d.sdaPrev = sdaS;
    sclRise = sclS && !st_q.sclPrev;
    sclFall = !sclS && st_q.sclPrev;
    startCond = sclS && st_q.sclPrev && st_q.sdaPrev && !sdaS;
    stopCond = sclS && st_q.sclPrev && !st_q.sdaPrev && sdaS;
    rxByte = {st_q.shift[6:0], sdaS};
    addrMatch = rxByte[7:5] == `CHP_I2C_ADDR_HI && (rxByte[4:1] == casc.addr || st_q.bcastI2c);
    ackOwner = casc.addr == 4'h0;
    rdByte = regRead(st_q.regs, st_q.index);
    wrEn = 1'b0;
    wrIdx = 3'h0;
    wrData = 8'h00;

    // ======================================================================
    // Local writes from the core; a pin write in the same cycle wins
    if (localWr.en)
    begin
      wrEn = 1'b1;
      wrIdx = localWr.idx;
      wrData = localWr.data;
    end

    unique case (st_q.mode)
      CHP_MODE_I2C:
      begin
        // ==================================================================
        // Two-wire read/write bus
        if (startCond)
        begin
          st_d.i2c = CHP_I2C_RX;
          st_d.bitCnt = 3'h0;
          st_d.byteNo = 2'h0;
          st_d.sdaOe = 1'b0;
        end
        else if (stopCond)
        begin
          st_d.i2c = CHP_I2C_IDLE;
          st_d.sdaOe = 1'b0;
        end
        else
        begin
          unique case (st_q.i2c)
            CHP_I2C_IDLE:
              st_d.sdaOe = 1'b0;
            CHP_I2C_RX:
            begin
              if (sclRise)
              begin
                st_d.shift = rxByte;
                st_d.bitCnt = st_q.bitCnt + 3'h1;
                if (st_q.bitCnt == 3'h7)
                begin
                  if (st_q.byteNo == 2'h0)
                  begin
                    st_d.hit = addrMatch;
                    st_d.rd = rxByte[0];
                    st_d.pendAck = addrMatch && ackOwner;
                    st_d.byteNo = 2'h1;
                  end
                  else if (st_q.byteNo == 2'h1)
                  begin
                    if (rxByte[7:3] == `CHP_I2C_MODE_BCAST)
                      st_d.bcastI2c = 1'b1;
                    else if (rxByte[7:3] == `CHP_I2C_MODE_DEFAULT)
                      st_d.bcastI2c = 1'b0;
                    st_d.index = rxByte[2:0];
                    st_d.pendAck = st_q.hit && (!st_d.bcastI2c || ackOwner);
                    st_d.byteNo = 2'h2;
                  end
                  else
                  begin
                    if (st_q.hit)
                    begin
                      wrEn = idxValid(st_q.index);
                      wrIdx = st_q.index;
                      wrData = rxByte;
                      st_d.index = st_q.index + 3'h1;
                    end
                    st_d.pendAck = st_q.hit && (!st_q.bcastI2c || ackOwner);
                  end
                end
              end
              else if (sclFall && st_q.bitCnt == 3'h0 && st_q.byteNo != 2'h0)
              begin
                st_d.i2c = CHP_I2C_ACK;
                st_d.sdaOut = 1'b0;
                st_d.sdaOe = st_q.pendAck;
              end
            end
            CHP_I2C_ACK:
            begin
              if (sclFall)
              begin
                st_d.sdaOe = 1'b0;
                st_d.bitCnt = 3'h0;
                if (!st_q.hit)
                  st_d.i2c = CHP_I2C_IDLE;
                else if (st_q.rd && st_q.byteNo == 2'h1)
                begin
                  // Read data starts at the current index
                  st_d.i2c = CHP_I2C_TX;
                  st_d.shift = rdByte;
                  st_d.sdaOe = !rdByte[7];
                  st_d.index = st_q.index + 3'h1;
                end
                else
                  st_d.i2c = CHP_I2C_RX;
              end
            end
            CHP_I2C_TX:
            begin
              if (sclFall)
              begin
                if (st_q.bitCnt == 3'h7)
                begin
                  st_d.i2c = CHP_I2C_MACK;
                  st_d.sdaOe = 1'b0;
                end
                else
                begin
                  st_d.bitCnt = st_q.bitCnt + 3'h1;
                  st_d.shift = {st_q.shift[6:0], 1'b0};
                  st_d.sdaOe = !st_q.shift[6];
                end
              end
            end
            CHP_I2C_MACK:
            begin
              if (sclRise)
                st_d.mAck = !sdaS;
              else if (sclFall)
              begin
                st_d.bitCnt = 3'h0;
                if (st_q.mAck)
                begin
                  st_d.i2c = CHP_I2C_TX;
                  st_d.shift = rdByte;
                  st_d.sdaOe = !rdByte[7];
                  st_d.index = st_q.index + 3'h1;
                end
                else
                  st_d.i2c = CHP_I2C_IDLE;
              end
            end
          endcase
        end
      end
      CHP_MODE_SS:
      begin
        // ==================================================================
        // Start/stop write-only link, sampled on clock rise
        st_d.sdaOe = 1'b0;
        st_d.i2c = CHP_I2C_IDLE;
        if (sclRise)
        begin
          if (!st_q.ssAct)
          begin
            if (!sdaS)
            begin
              st_d.ssAct = 1'b1;
              st_d.ssCnt = 5'h00;
            end
          end
          else if (st_q.ssCnt != `CHP_SS_BITS)
          begin
            st_d.ssWord = {st_q.ssWord[13:0], sdaS};
            st_d.ssCnt = st_q.ssCnt + 5'h01;
          end
          else
          begin
            st_d.ssAct = 1'b0;
            // A word without a high stop bit is dropped
            if (sdaS)
            begin
              if (st_q.ssWord == `CHP_SS_BCAST_ON)
                st_d.bcastSs = 1'b1;
              else if (st_q.ssWord == `CHP_SS_BCAST_OFF)
                st_d.bcastSs = 1'b0;
              else if (st_q.bcastSs || st_q.ssWord[14:11] == casc.addr)
              begin
                wrEn = idxValid(st_q.ssWord[10:8]);
                wrIdx = st_q.ssWord[10:8];
                wrData = st_q.ssWord[7:0];
              end
            end
          end
        end
      end
      CHP_MODE_GPIO:
      begin
        // ==================================================================
        // Pins as general-purpose I/O
        st_d.i2c = CHP_I2C_IDLE;
        st_d.ssAct = 1'b0;
        st_d.sdaOut = st_q.regs[`CHP_REG_PROTO][`CHP_GPIO_OUT_BIT];
        st_d.sdaOe = 1'b1;
      end
    endcase

    if (wrEn)
      st_d.regs[wrIdx] = wrData;
    // Input bit tracks the clock pin; it overrides any write to that bit
    if (st_q.mode == CHP_MODE_GPIO)
      st_d.regs[`CHP_REG_PROTO][`CHP_GPIO_IN_BIT] = sclS;
    if (st_q.mode != CHP_MODE_I2C || st_q.i2c == CHP_I2C_RX)
      st_d.sdaOut = (st_q.mode == CHP_MODE_GPIO) ? st_d.sdaOut : 1'b0;

    st_d.mode = modeOf(st_d.regs);
    st_d.bcastOut = st_d.bcastSs || st_d.bcastI2c;
    st_d.addr = casc.addr;
    st_d.master = casc.valid && ({1'b0, casc.addr} == casc.total - 5'h01);
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      st_q <= '0;
      st_q.regs <= {`CHP_RST_REG6, `CHP_RST_REG5, `CHP_RST_REG4,
                    `CHP_RST_REG3, `CHP_RST_REG2, `CHP_RST_REG1};
      st_q.mode <= CHP_MODE_I2C;
      st_q.sclPrev <= 1'b1;
      st_q.sdaPrev <= 1'b1;
      st_q.i2c <= CHP_I2C_IDLE;
    end
    else
      st_q <= st_d;
  end

  assign sdaPin = {st_q.sdaOut, st_q.sdaOe};
  assign ctrlRegs = st_q.regs;
  assign hostMode = st_q.mode;
  assign broadcastActive = st_q.bcastOut;
  assign cascadeAddr = st_q.addr;
  assign isMaster = st_q.master;

endmodule // chp_host_port

/* testbench/chp_host_port_assertions.sv */
`timescale 1ns/1ps
module chp_host_port_checker (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Watched ports
  input wire logic sclIn,
  input wire chp_pkg::chpPinOut_t sdaPin,
  input wire chp_pkg::chpLocalWr_t localWr,
  input wire chp_pkg::chpCtrlRegs_t ctrlRegs,
  input wire chp_pkg::chpMode_t hostMode,
  input wire logic broadcastActive
);
  import chp_pkg::*;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  reset_values_a: assert property ($rose(nrst) |-> ctrlRegs == 48'h0000_8000_0000 && !broadcastActive)
    else $error("registers not at reset values");
  proto_bus_a: assert property (ctrlRegs[4][7] |-> hostMode == CHP_MODE_I2C)
    else $error("bus protocol not selected");
  proto_link_a: assert property (!ctrlRegs[4][7] && ctrlRegs[2][1:0] == 2'h1 |-> hostMode == CHP_MODE_SS)
    else $error("start/stop link not selected");
  proto_gpio_a: assert property (!ctrlRegs[4][7] && ctrlRegs[2][1:0] != 2'h1 |-> hostMode == CHP_MODE_GPIO)
    else $error("pins not in general-purpose use");
  gpio_drive_a: assert property ((hostMode == CHP_MODE_GPIO)[*2] ##0 $stable(ctrlRegs[4][1])
    |-> sdaPin.sdaOe && sdaPin.sdaOut == ctrlRegs[4][1])
    else $error("data pin does not follow its register bit");
  gpio_input_a: assert property ((hostMode == CHP_MODE_GPIO && $stable(sclIn))[*8] |-> ctrlRegs[4][0] == sclIn)
    else $error("clock pin level not captured");
  drive_low_a: assert property ((hostMode != CHP_MODE_GPIO)[*2] |-> !sdaPin.sdaOut)
    else $error("data pin driven high outside general-purpose use");
  link_silent_a: assert property ((hostMode == CHP_MODE_SS)[*2] |-> !sdaPin.sdaOe)
    else $error("write-only link drives the data pin");
  local_write_a: assert property (localWr.en && localWr.idx inside {[3'h1:3'h6]}
    |=> ctrlRegs[$past(localWr.idx)][7:1] == $past(localWr.data[7:1]))
    else $error("core write lost");
endmodule // chp_host_port_checker

bind chp_host_port chp_host_port_checker i_checker (.clock(clock), .nrst(nrst), .sclIn(sclIn), .sdaPin(sdaPin),
  .localWr(localWr), .ctrlRegs(ctrlRegs), .hostMode(hostMode), .broadcastActive(broadcastActive));

/* testbench/chp_host_model.sv */
`timescale 1ns/1ps
// Host master: drives the clock pin, open-drain data line with a pull-up
module chp_host_model (
  // Clock
  input wire logic clock,
  // Device data pin
  input wire chp_pkg::chpPinOut_t sdaPin,
  // Wire levels
  output logic sclIn,
  output logic sdaIn
);
  import chp_pkg::*;
  logic hostSda = 1'b1;
  initial sclIn = 1'b1;
  // Low whenever either party pulls low; released means high
  assign sdaIn = hostSda & ~(sdaPin.sdaOe & ~sdaPin.sdaOut);

  // Levels held well past the device's pin synchroniser
  task automatic wt;
    repeat (12) @(posedge clock);
    #1;
  endtask
  task automatic bitIo(input logic b, output logic r);
    wt;
    hostSda = b;
    wt;
    sclIn = 1'b1;
    wt;
    r = sdaIn;
    sclIn = 1'b0;
  endtask
  task automatic start;
    wt;
    hostSda = 1'b1;
    wt;
    sclIn = 1'b1;
    wt;
    hostSda = 1'b0;
    wt;
    sclIn = 1'b0;
  endtask
  task automatic stop;
    wt;
    hostSda = 1'b0;
    wt;
    sclIn = 1'b1;
    wt;
    hostSda = 1'b1;
    wt;
  endtask
  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitIo(b[i], r);
    bitIo(1'b1, ack);
  endtask
  task automatic recvByte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitIo(1'b1, d[i]);
    bitIo(mack, r);
  endtask
  task automatic ssWord(input logic [14:0] w, input logic stp);
    logic r;
    sclIn = 1'b0;
    bitIo(1'b0, r);
    for (int i = 14; i >= 0; i--) bitIo(w[i], r);
    bitIo(stp, r);
    hostSda = 1'b1;
  endtask
  task automatic setScl(input logic v);
    sclIn = v;
  endtask
endmodule // chp_host_model

/* testbench/chp_host_port_bench.sv */
`timescale 1ns/1ps
`include "chp_defs.svh"
module chp_host_port_bench;
  import chp_pkg::*;
  logic clock, nrst, linkClock, linkNrst, sclIn, sdaIn, detectDone, broadcastActive, isMaster, a1, a2;
  logic [3:0] detectPos, cascadeAddr;
  logic [4:0] detectTotal;
  logic [7:0] d1, d2, r1, r2;
  logic [47:0] expQ[$];
  logic [47:0] resVal, expV;
  chpLocalWr_t localWr;
  chpPinOut_t sdaPin;
  chpCtrlRegs_t ctrlRegs;
  chpMode_t hostMode;
  int errors = 0;
  int n_checks = 0;
  event resEv;

  chp_host_port i_dut (.clock(clock), .nrst(nrst), .linkClock(linkClock), .linkNrst(linkNrst), .sclIn(sclIn),
    .sdaIn(sdaIn), .sdaPin(sdaPin), .detectDone(detectDone), .detectPos(detectPos), .detectTotal(detectTotal),
    .localWr(localWr), .ctrlRegs(ctrlRegs), .hostMode(hostMode), .broadcastActive(broadcastActive),
    .cascadeAddr(cascadeAddr), .isMaster(isMaster));
  chp_host_model i_host (.clock(clock), .sdaPin(sdaPin), .sclIn(sclIn), .sdaIn(sdaIn));

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial
  begin
    linkClock = 1'b0;
    #1.7;
    forever #3 linkClock = ~linkClock;
  end

  // ==========
  // Notes are taken in order as results arrive
  initial
  begin
    forever
    begin
      @(resEv);
      expV = expQ.pop_front();
      n_checks++;
      if (expV !== resVal)
      begin
        errors++;
        $display("ERROR at %0t: expected %h got %h", $time, expV, resVal);
      end
    end
  end
  task automatic chk(input logic [47:0] want, input logic [47:0] seen);
    expQ.push_back(want);
    resVal = seen;
    ->resEv;
    #0.1;
  endtask
  task automatic settle;
    repeat (12) @(posedge clock);
    #1;
  endtask
  task automatic lw(input logic [2:0] idx, input logic [7:0] data);
    @(posedge clock);
    #1;
    localWr = {1'b1, idx, data};
    @(posedge clock);
    #1;
    localWr = '0;
    settle;
  endtask
  task automatic casc(input logic [3:0] pos, input logic [4:0] total, input logic [3:0] ea, input logic em);
    @(posedge linkClock);
    #1;
    detectDone = 1'b1;
    detectPos = pos;
    detectTotal = total;
    @(posedge linkClock);
    #1;
    detectDone = 1'b0;
    settle;
    chk({43'h0, ea, em}, {43'h0, cascadeAddr, isMaster});
  endtask
  task automatic head(input logic [3:0] addr, input logic [7:0] modeIdx);
    i_host.start;
    i_host.sendByte({`CHP_I2C_ADDR_HI, addr, 1'b0}, a1);
    i_host.sendByte(modeIdx, a2);
  endtask
  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    #400000;
    errors++;
    $display("ERROR at %0t: watchdog expired, expected %h got %h", $time, 1'b1, 1'b0);
    print_verdict;
  end

  // ==========
  // Main sequence
  initial
  begin
    void'($urandom(32'h73e56bc4));
    nrst = 1'b0;
    linkNrst = 1'b0;
    localWr = '0;
    detectDone = 1'b0;
    detectPos = '0;
    detectTotal = '0;
    repeat (2) @(posedge clock);
    #1;
    nrst = 1'b1;
    linkNrst = 1'b1;
    settle;
    chk(48'h0000_8000_0000, ctrlRegs);
    chk(48'(CHP_MODE_I2C), 48'(hostMode));
    casc(4'h2, 5'h4, 4'h2, 1'b0);
    casc(4'hf, 5'h10, 4'hf, 1'b1);
    casc(4'h0, 5'h1, 4'h0, 1'b1);
    casc(4'h5, 5'h3, 4'h0, 1'b1);
    $display("Reset and cascade tests done");
    head(4'h0, {`CHP_I2C_MODE_BCAST, 3'h2});
    i_host.sendByte(8'h01, a1);
    i_host.stop;
    chk(48'h0, {46'h0, a1, a2});
    chk(48'h101, {39'h0, broadcastActive, ctrlRegs[2]});
    d1 = 8'($urandom);
    d2 = 8'($urandom);
    head(4'h0, {`CHP_I2C_MODE_DEFAULT, 3'h5});
    i_host.sendByte(d1, a1);
    i_host.sendByte(d2, a2);
    i_host.stop;
    chk(48'h0, {46'h0, a1, a2});
    chk({32'h0, d1, d2}, {31'h0, broadcastActive, ctrlRegs[5], ctrlRegs[6]});
    head(4'h0, {`CHP_I2C_MODE_DEFAULT, 3'h5});
    i_host.start;
    i_host.sendByte({`CHP_I2C_ADDR_HI, 4'h0, 1'b1}, a1);
    i_host.recvByte(1'b0, r1);
    i_host.recvByte(1'b1, r2);
    i_host.stop;
    chk({32'h0, d1, d2}, {31'h0, a1, r1, r2});
    head(4'h9, 8'h05);
    i_host.stop;
    chk(48'h3, {46'h0, a1, a2});
    $display("Bus tests done");
    lw(3'h4, 8'h00);
    chk(48'(CHP_MODE_SS), 48'(hostMode));
    i_host.ssWord({4'h0, 3'h1, d1}, 1'b1);
    chk(48'(d1), 48'(ctrlRegs[1]));
    i_host.ssWord({4'h3, 3'h1, ~d1}, 1'b1);
    i_host.ssWord({4'h0, 3'h3, d2}, 1'b0);
    chk({40'h0, d1}, {32'h0, ctrlRegs[3], ctrlRegs[1]});
    i_host.ssWord(`CHP_SS_BCAST_ON, 1'b1);
    chk(48'h1, 48'(broadcastActive));
    i_host.ssWord({4'h5, 3'h3, d2}, 1'b1);
    chk(48'(d2), 48'(ctrlRegs[3]));
    i_host.ssWord(`CHP_SS_BCAST_OFF, 1'b1);
    i_host.ssWord({4'h5, 3'h3, d1}, 1'b1);
    chk({39'h0, 1'b0, d2}, {39'h0, broadcastActive, ctrlRegs[3]});
    $display("Link tests done");
    i_host.ssWord({4'h0, 3'h2, 8'h00}, 1'b1);
    lw(3'h4, 8'h02);
    chk(48'(CHP_MODE_GPIO), 48'(hostMode));
    chk(48'h6, {45'h0, sdaPin.sdaOe, sdaPin.sdaOut, ctrlRegs[4][0]});
    i_host.setScl(1'b1);
    settle;
    chk(48'h7, {45'h0, sdaPin.sdaOe, sdaPin.sdaOut, ctrlRegs[4][0]});
    lw(3'h4, 8'h01);
    chk(48'h5, {45'h0, sdaPin.sdaOe, sdaPin.sdaOut, ctrlRegs[4][0]});
    $display("Pin tests done");
    print_verdict;
  end
endmodule // chp_host_port_bench
